// *** verilog/cfl_config_fuse_loader.sv ***
// configuration fuse bank with start-up loader into peripheral targets
//
// What this block does
// - processor and debug link read fuses; only the debug link programs or clears
// - during start-up the watchdog, brown-out, oscillator and system A fields are copied to their target registers
// - new fuse values act only after a reset and reload
// - watchdog byte 7:4 to window field, 3:0 to time-out period field
// - brown-out byte 7:5 to threshold field; codes above 3 reserved
// - brown-out bit 4 to sample-rate bit: 0 is 128 Hz, 1 is 32 Hz
// - brown-out bits 3:2 to active-mode field; code 3 continuous with wake hold
// - active code 3 holds execution after wake-up until brown-out detector runs
// - brown-out bits 1:0 to sleep-mode field; code 3 reserved
// - oscillator byte bits 3:0 pick default oscillator: 0 fast, 1 slow
// - system byte bits 7:6 pick flash region for start-up scan
// - system byte bit 5 picks scan polynomial: 0 16-bit, 1 32-bit
// - system byte bit 4 sets debug pin role: 0 gpio, 1 debug link
// - system byte bit 3 sets reset pin role: 0 input, 1 external reset
// - shipped fuse contents are factory defaults, not register reset values
// - keep-boot-row bit saves boot row on chip erase unless device locked
// - keep-eeprom bit saves eeprom on chip erase, locked or not
`timescale 1ns/1ps
module cfl_config_fuse_loader
  import cfl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic factory_init_i,
  input wire logic cpu_rd_i,
  input wire logic cpu_wr_i,
  input wire logic [cfl_pkg::ADDR_W-1:0] cpu_addr_i,
  output logic [cfl_pkg::DATA_W-1:0] cpu_rdata_o,
  output logic cpu_rvalid_o,
  output logic cpu_wr_refused_o,
  input wire logic link_rd_i,
  input wire logic link_wr_i,
  input wire logic link_clr_i,
  input wire logic [cfl_pkg::ADDR_W-1:0] link_addr_i,
  input wire logic [cfl_pkg::DATA_W-1:0] link_wdata_i,
  output logic [cfl_pkg::DATA_W-1:0] link_rdata_o,
  output logic link_rvalid_o,
  output logic link_wr_done_o,
  input wire logic wakeup_i,
  input wire logic bod_running_i,
  input wire logic chip_erase_i,
  input wire logic locked_i,
  output logic [3:0] wdt_window_o,
  output logic [3:0] wdt_period_o,
  output logic [2:0] brownout_threshold_field_o,
  output logic brownout_sample_rate_bit_o,
  output logic [1:0] brownout_active_mode_o,
  output logic [1:0] brownout_sleep_mode_o,
  output logic [3:0] default_oscillator_select_o,
  output logic [1:0] scan_region_select_o,
  output logic scan_polynomial_select_o,
  output logic debug_pin_role_bit_o,
  output logic reset_pin_role_bit_o,
  output logic load_done_o,
  output logic cpu_run_o,
  output logic erase_flash_o,
  output logic erase_boot_row_o,
  output logic erase_eeprom_o
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [FUSE_BYTES-1:0][DATA_W-1:0] fuse;
  cfl_load_state_type state_q;
  cfl_load_state_type state_d;
  logic [DATA_W-1:0] sys_byte_q;
  logic exec_hold_q;
  logic link_wr_ok;
  logic link_clr_ok;

  // ----------------------------------------
  // fuse storage
  // ----------------------------------------
  // processor writes never reach the store
  assign link_wr_ok = link_wr_i && (link_addr_i <= OFS_LAST);
  assign link_clr_ok = link_clr_i && (link_addr_i <= OFS_LAST);

  cfl_fuse_store u_store (
    .mclk_i(mclk_i),
    .factory_init_i(factory_init_i),
    .wr_en_i(link_wr_ok),
    .clr_en_i(link_clr_ok),
    .addr_i(link_addr_i),
    .wdata_i(link_wdata_i),
    .fuse_o(fuse)
  );

  // ----------------------------------------
  // processor read port
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cpu_rdata_o <= BYTE_ZERO;
      cpu_rvalid_o <= 1'b0;
    end else begin
      cpu_rvalid_o <= cpu_rd_i;
      if (cpu_rd_i) begin
        if (cpu_addr_i <= OFS_LAST) begin
          cpu_rdata_o <= fuse[cpu_addr_i];
        end else begin
          cpu_rdata_o <= BYTE_ZERO;
        end
      end
    end
  end

  // ----------------------------------------
  // processor write refusal
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cpu_wr_refused_o <= 1'b0;
    end else begin
      cpu_wr_refused_o <= cpu_wr_i;
    end
  end

  // ----------------------------------------
  // debug link read and write port
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      link_rdata_o <= BYTE_ZERO;
      link_rvalid_o <= 1'b0;
      link_wr_done_o <= 1'b0;
    end else begin
      link_rvalid_o <= link_rd_i;
      link_wr_done_o <= link_wr_ok || link_clr_ok;
      if (link_rd_i) begin
        if (link_addr_i <= OFS_LAST) begin
          link_rdata_o <= fuse[link_addr_i];
        end else begin
          link_rdata_o <= BYTE_ZERO;
        end
      end
    end
  end

  // ----------------------------------------
  // start-up loader sequence
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      LD_IDLE: begin
        state_d = LD_WATCHDOG;
      end
      LD_WATCHDOG: begin
        state_d = LD_BROWNOUT;
      end
      LD_BROWNOUT: begin
        state_d = LD_OSCILLATOR;
      end
      LD_OSCILLATOR: begin
        state_d = LD_SYSTEM;
      end
      LD_SYSTEM: begin
        state_d = LD_DONE;
      end
      LD_DONE: begin
        state_d = LD_DONE;
      end
      default: begin
        state_d = LD_IDLE;
      end
    endcase
  end

  // only a reset restarts the walk, so live fuse edits wait for it
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q <= LD_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // watchdog targets
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wdt_window_o <= 4'h0;
      wdt_period_o <= 4'h0;
    end else if (state_q == LD_WATCHDOG) begin
      wdt_window_o <= fuse[OFS_WATCHDOG][WDT_WINDOW_LSB +: 4];
      wdt_period_o <= fuse[OFS_WATCHDOG][WDT_PERIOD_LSB +: 4];
    end
  end

  // ----------------------------------------
  // brown-out targets
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      brownout_threshold_field_o <= 3'h0;
      brownout_sample_rate_bit_o <= 1'b0;
      brownout_active_mode_o <= 2'h0;
      brownout_sleep_mode_o <= 2'h0;
    end else if (state_q == LD_BROWNOUT) begin
      // raw copy, reserved codes included
      brownout_threshold_field_o <= fuse[OFS_BROWNOUT][BOD_LEVEL_LSB +: 3];
      brownout_sample_rate_bit_o <= fuse[OFS_BROWNOUT][BOD_RATE_BIT];
      brownout_active_mode_o <= fuse[OFS_BROWNOUT][BOD_ACTIVE_LSB +: 2];
      brownout_sleep_mode_o <= fuse[OFS_BROWNOUT][BOD_SLEEP_LSB +: 2];
    end
  end

  // ----------------------------------------
  // oscillator target
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      default_oscillator_select_o <= 4'h0;
    end else if (state_q == LD_OSCILLATOR) begin
      default_oscillator_select_o <= fuse[OFS_OSCILLATOR][OSC_SELECT_LSB +: 4];
    end
  end

  // ----------------------------------------
  // system targets
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sys_byte_q <= BYTE_ZERO;
      scan_region_select_o <= 2'h0;
      scan_polynomial_select_o <= 1'b0;
      debug_pin_role_bit_o <= 1'b0;
      reset_pin_role_bit_o <= 1'b0;
    end else if (state_q == LD_SYSTEM) begin
      sys_byte_q <= fuse[OFS_SYSTEM_A];
      scan_region_select_o <= fuse[OFS_SYSTEM_A][SCAN_REGION_LSB +: 2];
      scan_polynomial_select_o <= fuse[OFS_SYSTEM_A][SCAN_POLY_BIT];
      debug_pin_role_bit_o <= fuse[OFS_SYSTEM_A][DEBUG_PIN_BIT];
      reset_pin_role_bit_o <= fuse[OFS_SYSTEM_A][RESET_PIN_BIT];
    end
  end

  // ----------------------------------------
  // processor release
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      load_done_o <= 1'b0;
    end else begin
      load_done_o <= (state_q == LD_SYSTEM) || (state_q == LD_DONE);
    end
  end

  // ----------------------------------------
  // wake-up hold until brown-out detector runs
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      exec_hold_q <= 1'b0;
    end else if (bod_running_i) begin
      exec_hold_q <= 1'b0;
    end else if (wakeup_i && brownout_active_mode_o == CONTINUOUS_HOLD_WAKEUP_CODE) begin
      exec_hold_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cpu_run_o <= 1'b0;
    end else begin
      cpu_run_o <= load_done_o && !exec_hold_q && !(wakeup_i && !bod_running_i
        && brownout_active_mode_o == CONTINUOUS_HOLD_WAKEUP_CODE);
    end
  end

  // ----------------------------------------
  // chip erase, using loaded save bits
  // ----------------------------------------
  cfl_erase_guard u_erase (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .erase_req_i(chip_erase_i && load_done_o),
    .locked_i(locked_i),
    .keep_boot_row_bit_i(sys_byte_q[KEEP_BOOT_BIT]),
    .keep_eeprom_bit_i(sys_byte_q[KEEP_EEPROM_BIT]),
    .erase_flash_o(erase_flash_o),
    .erase_boot_row_o(erase_boot_row_o),
    .erase_eeprom_o(erase_eeprom_o)
  );

endmodule

// *** include/cfl_pkg.sv ***
// package: offsets, field layout, shipped defaults and states of the fuse loader
package cfl_pkg;

  // ----------------------------------------
  // fuse array geometry
  // ----------------------------------------
  localparam int FUSE_BYTES = 12;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // ----------------------------------------
  // fuse byte offsets
  // ----------------------------------------
  localparam logic [3:0] OFS_WATCHDOG = 4'h0;
  localparam logic [3:0] OFS_BROWNOUT = 4'h1;
  localparam logic [3:0] OFS_OSCILLATOR = 4'h2;
  localparam logic [3:0] OFS_SYSTEM_A = 4'h5;
  localparam logic [3:0] OFS_SYSTEM_B = 4'h6;
  localparam logic [3:0] OFS_CODE_SIZE = 4'h7;
  localparam logic [3:0] OFS_BOOT_SIZE = 4'h8;
  localparam logic [3:0] OFS_PROTECT_LO = 4'ha;
  localparam logic [3:0] OFS_PROTECT_HI = 4'hb;
  localparam logic [3:0] OFS_LAST = 4'hb;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int WDT_WINDOW_LSB = 4;
  localparam int WDT_PERIOD_LSB = 0;
  localparam int BOD_LEVEL_LSB = 5;
  localparam int BOD_RATE_BIT = 4;
  localparam int BOD_ACTIVE_LSB = 2;
  localparam int BOD_SLEEP_LSB = 0;
  localparam int OSC_SELECT_LSB = 0;
  localparam int SCAN_REGION_LSB = 6;
  localparam int SCAN_POLY_BIT = 5;
  localparam int DEBUG_PIN_BIT = 4;
  localparam int RESET_PIN_BIT = 3;
  localparam int KEEP_BOOT_BIT = 1;
  localparam int KEEP_EEPROM_BIT = 0;
  localparam logic [1:0] CONTINUOUS_HOLD_WAKEUP_CODE = 2'h3;

  // ----------------------------------------
  // implemented bits and shipped defaults per byte
  // ----------------------------------------
  localparam logic [DATA_W-1:0] FUSE_MASK [FUSE_BYTES] = '{
    8'hff, 8'hff, 8'h0f, 8'h00, 8'h00, 8'hfb,
    8'h0f, 8'hff, 8'hff, 8'h00, 8'hf3, 8'hff};
  localparam logic [DATA_W-1:0] FUSE_SHIPPED [FUSE_BYTES] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hd0,
    8'h08, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};

  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------
  // loader states
  // ----------------------------------------
  typedef enum logic [2:0] {
    LD_IDLE, LD_WATCHDOG, LD_BROWNOUT, LD_OSCILLATOR, LD_SYSTEM, LD_DONE
  } cfl_load_state_type;

endpackage

// *** verilog/cfl_fuse_store.sv ***
// nonvolatile fuse byte array, loaded with shipped defaults by factory init, otherwise written only through the debug link port
`timescale 1ns/1ps
module cfl_fuse_store
  import cfl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic factory_init_i,
  input wire logic wr_en_i,
  input wire logic clr_en_i,
  input wire logic [cfl_pkg::ADDR_W-1:0] addr_i,
  input wire logic [cfl_pkg::DATA_W-1:0] wdata_i,
  output logic [cfl_pkg::FUSE_BYTES-1:0][cfl_pkg::DATA_W-1:0] fuse_o
);

  // ----------------------------------------
  // one byte per entry, kept through reset
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < FUSE_BYTES; g = g + 1) begin : g_byte
      logic [DATA_W-1:0] byte_q;
      always_ff @(posedge mclk_i) begin
        if (factory_init_i) begin
          byte_q <= FUSE_SHIPPED[g];
        end else if (clr_en_i && addr_i == ADDR_W'(g)) begin
          byte_q <= BYTE_ZERO;
        end else if (wr_en_i && addr_i == ADDR_W'(g)) begin
          byte_q <= wdata_i & FUSE_MASK[g];
        end
      end
      assign fuse_o[g] = byte_q;
    end
  endgenerate

endmodule

// *** verilog/cfl_erase_guard.sv ***
// decides which nonvolatile sections a chip erase wipes
`timescale 1ns/1ps
module cfl_erase_guard (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic erase_req_i,
  input wire logic locked_i,
  input wire logic keep_boot_row_bit_i,
  input wire logic keep_eeprom_bit_i,
  output logic erase_flash_o,
  output logic erase_boot_row_o,
  output logic erase_eeprom_o
);

  // ----------------------------------------
  // erase strobes
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      erase_flash_o <= 1'b0;
      erase_boot_row_o <= 1'b0;
      erase_eeprom_o <= 1'b0;
    end else begin
      erase_flash_o <= erase_req_i;
      erase_boot_row_o <= erase_req_i && (locked_i || !keep_boot_row_bit_i);
      erase_eeprom_o <= erase_req_i && !keep_eeprom_bit_i;
    end
  end

endmodule

// *** verification/cfl_config_fuse_loader_chk.sv ***
// checker for the fuse loader port timing
`timescale 1ns/1ps
module cfl_chk (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic cpu_rd_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rvalid_o,
  input wire logic cpu_wr_refused_o,
  input wire logic link_rd_i,
  input wire logic link_wr_i,
  input wire logic link_clr_i,
  input wire logic [cfl_pkg::ADDR_W-1:0] link_addr_i,
  input wire logic link_rvalid_o,
  input wire logic link_wr_done_o,
  input wire logic wakeup_i,
  input wire logic bod_running_i,
  input wire logic chip_erase_i,
  input wire logic locked_i,
  input wire logic [3:0] wdt_period_o,
  input wire logic [1:0] brownout_active_mode_o,
  input wire logic load_done_o,
  input wire logic cpu_run_o,
  input wire logic erase_flash_o,
  input wire logic erase_boot_row_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_read_answer: assert property (cpu_rd_i |=> cpu_rvalid_o) else $error("no read answer");
  a_read_quiet: assert property (!cpu_rd_i |=> !cpu_rvalid_o) else $error("stray read valid");
  a_write_refused: assert property (cpu_wr_i |=> cpu_wr_refused_o) else $error("write not refused");
  a_link_program: assert property ((link_wr_i || link_clr_i) && link_addr_i <= 4'hb
    |=> link_wr_done_o) else $error("link program not done");
  a_link_read: assert property (link_rd_i |=> link_rvalid_o) else $error("no link read answer");
  a_run_after_load: assert property ($rose(cpu_run_o) |-> $past(load_done_o))
    else $error("run before load");
  a_targets_hold: assert property (load_done_o && $past(load_done_o)
    |-> $stable(wdt_period_o) && $stable(brownout_active_mode_o)) else $error("target moved");
  a_erase_answer: assert property (chip_erase_i && load_done_o |=> erase_flash_o)
    else $error("no erase");
  a_erase_locked: assert property (erase_flash_o && $past(locked_i) |-> erase_boot_row_o)
    else $error("boot row kept when locked");
  a_wake_hold: assert property (brownout_active_mode_o == 2'h3 && wakeup_i && !bod_running_i
    && cpu_run_o |=> !cpu_run_o[*2]) else $error("wake not held");
endmodule
bind cfl_config_fuse_loader cfl_chk cfl_chk_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .cpu_rd_i(cpu_rd_i), .cpu_wr_i(cpu_wr_i), .cpu_rvalid_o(cpu_rvalid_o),
  .cpu_wr_refused_o(cpu_wr_refused_o), .link_rd_i(link_rd_i), .link_wr_i(link_wr_i),
  .link_clr_i(link_clr_i), .link_addr_i(link_addr_i), .link_rvalid_o(link_rvalid_o),
  .link_wr_done_o(link_wr_done_o), .wakeup_i(wakeup_i), .bod_running_i(bod_running_i),
  .chip_erase_i(chip_erase_i), .locked_i(locked_i), .wdt_period_o(wdt_period_o),
  .brownout_active_mode_o(brownout_active_mode_o), .load_done_o(load_done_o),
  .cpu_run_o(cpu_run_o), .erase_flash_o(erase_flash_o), .erase_boot_row_o(erase_boot_row_o));

// *** verification/cfl_link_prog.sv ***
// programmer model on the single pin debug link
`timescale 1ns/1ps
module cfl_link_prog
  import cfl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [cfl_pkg::DATA_W-1:0] link_rdata_i,
  input wire logic link_rvalid_i,
  input wire logic link_wr_done_i,
  output logic link_rd_o,
  output logic link_wr_o,
  output logic link_clr_o,
  output logic [cfl_pkg::ADDR_W-1:0] link_addr_o,
  output logic [cfl_pkg::DATA_W-1:0] link_wdata_o
);
  initial begin
    {link_rd_o, link_wr_o, link_clr_o, link_addr_o, link_wdata_o} = '0;
  end
  // one request held over one edge, answer taken one cycle later
  task automatic op(input logic rd, input logic wr, input logic clr, input logic [3:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic ok);
    @(negedge mclk_i);
    link_rd_o = rd;
    link_wr_o = wr; // only the link programs fuses
    link_clr_o = clr;
    link_addr_o = a;
    link_wdata_o = d & FUSE_MASK[a]; // reserved bits written as zero
    @(negedge mclk_i);
    q = link_rdata_i;
    ok = rd ? link_rvalid_i : link_wr_done_i;
    {link_rd_o, link_wr_o, link_clr_o} = 3'h0;
    link_addr_o = ~a;
    link_wdata_o = ~link_wdata_o;
  endtask
endmodule

// *** verification/cfl_config_fuse_loader_bench.sv ***
// self-checking bench for the fuse loader
`timescale 1ns/1ps
module cfl_config_fuse_loader_bench;
  import cfl_pkg::*;
  logic mclk_i = 0, rst_n_i = 0, factory_init_i = 0, cpu_rd_i = 0, cpu_wr_i = 0;
  logic [3:0] cpu_addr_i = 4'h0;
  logic wakeup_i = 0, bod_running_i = 1, chip_erase_i = 0, locked_i = 0;
  logic link_rd, link_wr, link_clr, link_rvalid, link_wr_done, cpu_rvalid, cpu_wr_refused;
  logic [3:0] link_addr, wdt_window, wdt_period, osc_sel;
  logic [7:0] link_wdata, link_rdata, cpu_rdata, q;
  logic [2:0] bod_level;
  logic [1:0] bod_active, bod_sleep, scan_region;
  logic bod_rate, scan_poly, dbg_role, rst_role, load_done, cpu_run, er_fl, er_bt, er_ee, ok;
  int fail_count = 0, checks = 0, cycles = 0;
  always #12.5 mclk_i = ~mclk_i;
  cfl_config_fuse_loader cfl_config_fuse_loader_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .factory_init_i(factory_init_i), .cpu_rd_i(cpu_rd_i), .cpu_wr_i(cpu_wr_i),
    .cpu_addr_i(cpu_addr_i), .cpu_rdata_o(cpu_rdata), .cpu_rvalid_o(cpu_rvalid),
    .cpu_wr_refused_o(cpu_wr_refused), .link_rd_i(link_rd), .link_wr_i(link_wr),
    .link_clr_i(link_clr), .link_addr_i(link_addr), .link_wdata_i(link_wdata),
    .link_rdata_o(link_rdata), .link_rvalid_o(link_rvalid), .link_wr_done_o(link_wr_done),
    .wakeup_i(wakeup_i), .bod_running_i(bod_running_i), .chip_erase_i(chip_erase_i),
    .locked_i(locked_i), .wdt_window_o(wdt_window), .wdt_period_o(wdt_period),
    .brownout_threshold_field_o(bod_level), .brownout_sample_rate_bit_o(bod_rate),
    .brownout_active_mode_o(bod_active), .brownout_sleep_mode_o(bod_sleep),
    .default_oscillator_select_o(osc_sel), .scan_region_select_o(scan_region),
    .scan_polynomial_select_o(scan_poly), .debug_pin_role_bit_o(dbg_role),
    .reset_pin_role_bit_o(rst_role), .load_done_o(load_done), .cpu_run_o(cpu_run),
    .erase_flash_o(er_fl), .erase_boot_row_o(er_bt), .erase_eeprom_o(er_ee));
  cfl_link_prog cfl_link_prog_inst (.mclk_i(mclk_i), .link_rdata_i(link_rdata),
    .link_rvalid_i(link_rvalid), .link_wr_done_i(link_wr_done), .link_rd_o(link_rd),
    .link_wr_o(link_wr), .link_clr_o(link_clr), .link_addr_o(link_addr),
    .link_wdata_o(link_wdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic do_reset();
    @(negedge mclk_i);
    rst_n_i = 0;
    repeat (6) @(negedge mclk_i);
    rst_n_i = 1;
    repeat (8) @(negedge mclk_i);
  endtask
  task automatic cpu_op(input logic wr, input logic [3:0] a);
    @(negedge mclk_i);
    cpu_rd_i = !wr;
    cpu_wr_i = wr;
    cpu_addr_i = a;
    @(negedge mclk_i);
    {cpu_rd_i, cpu_wr_i} = 2'h0;
    cpu_addr_i = ~a;
    q = cpu_rdata;
    ok = wr ? cpu_wr_refused : cpu_rvalid;
  endtask
  task automatic targets(input logic [7:0] wdt, bod, osc, sys);
    chk({wdt_window, wdt_period}, wdt);
    chk({bod_level, bod_rate, bod_active, bod_sleep}, bod);
    chk({4'h0, osc_sel}, osc);
    chk({scan_region, scan_poly, dbg_role, rst_role, 3'h0}, sys & 8'hf8);
    chk({6'h0, cpu_run, load_done}, 8'h03);
  endtask
  task automatic erase(input logic lock, input logic [2:0] exp);
    @(negedge mclk_i);
    locked_i = lock;
    chip_erase_i = 1;
    @(negedge mclk_i);
    chip_erase_i = 0;
    chk({5'h0, er_fl, er_bt, er_ee}, {5'h0, exp});
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    @(negedge mclk_i);
    factory_init_i = 1;
    @(negedge mclk_i);
    factory_init_i = 0;
    do_reset();
    targets(8'h00, 8'h00, 8'h00, 8'hd0);
    for (int i = 0; i < 13; i++) begin
      cpu_op(0, 4'(i));
      chk(q, (i < FUSE_BYTES) ? FUSE_SHIPPED[i] : BYTE_ZERO);
      chk({7'h0, ok}, 8'h01);
    end
    $display("test shipped_defaults done");
    cpu_op(1, OFS_BROWNOUT);
    chk({7'h0, ok}, 8'h01);
    cpu_op(0, OFS_BROWNOUT);
    chk(q, 8'h00);
    $display("test cpu_write_refused done");
    cfl_link_prog_inst.op(0, 1, 0, OFS_WATCHDOG, 8'ha5, q, ok);
    cfl_link_prog_inst.op(0, 1, 0, OFS_BROWNOUT, 8'hed, q, ok);
    cfl_link_prog_inst.op(0, 1, 0, OFS_OSCILLATOR, 8'hf3, q, ok);
    cfl_link_prog_inst.op(0, 1, 0, OFS_SYSTEM_A, 8'h6b, q, ok);
    chk({7'h0, ok}, 8'h01);
    cpu_op(0, OFS_BROWNOUT);
    chk(q, 8'hed);
    targets(8'h00, 8'h00, 8'h00, 8'hd0);
    do_reset();
    targets(8'ha5, 8'hed, 8'h03, 8'h6b);
    $display("test link_program_reload done");
    @(negedge mclk_i);
    bod_running_i = 0;
    wakeup_i = 1;
    @(negedge mclk_i);
    wakeup_i = 0;
    repeat (2) @(negedge mclk_i);
    chk({7'h0, cpu_run}, 8'h00);
    bod_running_i = 1;
    repeat (2) @(negedge mclk_i);
    chk({7'h0, cpu_run}, 8'h01);
    $display("test wake_hold done");
    erase(0, 3'b100);
    erase(1, 3'b110);
    cfl_link_prog_inst.op(0, 0, 1, OFS_SYSTEM_A, 8'hff, q, ok);
    cfl_link_prog_inst.op(1, 0, 0, OFS_SYSTEM_A, 8'h00, q, ok);
    chk(q, 8'h00);
    chk({7'h0, ok}, 8'h01);
    do_reset();
    targets(8'ha5, 8'hed, 8'h03, 8'h00);
    erase(0, 3'b111);
    $display("test clear_and_erase done");
    test_done();
  end
endmodule
